//--- rtl/bus_decode_defines.vh
// Address map, region sizes and timing constants for the system bus decoder
`ifndef BUS_DECODE_DEFINES_VH
`define BUS_DECODE_DEFINES_VH

`define SRAM_BASE        32'h0000_0000
`define FLASH_BASE       32'h8000_0000
`define USB_BASE         32'hd000_0000
`define BRIDGE_A_BASE    32'hffff_0000
`define BRIDGE_B_BASE    32'hfffe_0000
`define WIN_64K_SIZE     32'h0001_0000

// Region sizes per variant, in bytes
`define SRAM_SIZE_96K    32'h0001_8000
`define SRAM_SIZE_32K    32'h0000_8000
`define SRAM_SIZE_16K    32'h0000_4000
`define FLASH_SIZE_512K  32'h0008_0000
`define FLASH_SIZE_256K  32'h0004_0000
`define FLASH_SIZE_128K  32'h0002_0000
`define FLASH_SIZE_64K   32'h0001_0000

// Flash wait-state thresholds, in MHz
`define FLASH_WS0_MAX_MHZ 30
`define FLASH_WS1_MAX_MHZ 60
`define SYS_CLK_MHZ       50

// Target select codes
`define TGT_NONE     3'h0
`define TGT_SRAM     3'h1
`define TGT_FLASH    3'h2
`define TGT_USB      3'h3
`define TGT_BRIDGE_A 3'h4
`define TGT_BRIDGE_B 3'h5

// Priority register field layout
`define PRIO_FIELD_W 2
`define PRIO_NIBBLES 8

`endif

//--- rtl/addr_region_match.v
// Combinational decode of one bus address to a target region
`timescale 1ns/1ps
`include "bus_decode_defines.vh"

module addr_region_match #(
  parameter [31:0] SRAM_SIZE  = `SRAM_SIZE_32K,
  parameter [31:0] FLASH_SIZE = `FLASH_SIZE_128K
) (
  input  wire [31:0] addr,
  output reg  [2:0]  target
);

  // True when a lies in [base, base+size)
  function in_region;
    input [31:0] a;
    input [31:0] base;
    input [31:0] size;
    begin
      in_region = (a >= base) && ((a - base) < size);
    end
  endfunction

  // Flat address, fixed map, never remapped; unmapped gives none
  always @* begin
    target = `TGT_NONE;
    if (in_region(addr, `SRAM_BASE, SRAM_SIZE)) begin
      target = `TGT_SRAM;
    end else if (in_region(addr, `FLASH_BASE, FLASH_SIZE)) begin
      target = `TGT_FLASH;
    end else if (in_region(addr, `USB_BASE, `WIN_64K_SIZE)) begin
      target = `TGT_USB;
    end else if (in_region(addr, `BRIDGE_A_BASE, `WIN_64K_SIZE)) begin
      target = `TGT_BRIDGE_A;
    end else if (in_region(addr, `BRIDGE_B_BASE, `WIN_64K_SIZE)) begin
      target = `TGT_BRIDGE_B;
    end
  end

endmodule // addr_region_match

//--- rtl/prio_field_mask.v
// Narrows priority register fields to two bits per nibble
`timescale 1ns/1ps
`include "bus_decode_defines.vh"

module prio_field_mask (
  input  wire [31:0] wdata,
  output wire [31:0] stored
);

  genvar i;
  // Upper two bits of each nibble have no storage and read as zero
  generate
    for (i = 0; i < `PRIO_NIBBLES; i = i + 1) begin : g_nib
      assign stored[4*i+1:4*i] = wdata[4*i+1:4*i];
      assign stored[4*i+3:4*i+2] = 2'h0;
    end
  endgenerate

endmodule // prio_field_mask

//--- rtl/system_bus_address_decoder.v
// System bus decoder with flash wait states, bursts and priority regs
`timescale 1ns/1ps
`include "bus_decode_defines.vh"

// Behaviour
// - Fixed target map for all addresses, no remapping even during boot.
// - Addresses are a flat 32-bit physical space without translation.
// - SRAM at 0x0000_0000, flash at 0x8000_0000.
// - USB buffer at 0xD000_0000, bridge A 0xFFFF_0000, bridge B 0xFFFE_0000.
// - USB, bridge A and bridge B windows each span 64 Kbytes.
// - SRAM size is a variant parameter: 96, 32 or 16 KB.
// - Flash size is a variant parameter: 512, 256, 128 or 64 KB.
// - Flash reads take zero wait states at or below 30 MHz.
// - Flash reads take one wait state above 30 MHz up to 60 MHz.
// - Sequential flash bursts return one word per cycle after the first.
// - SRAM reads and writes finish in one cycle, no wait states.
// - Master priority fields hold two bits; other nibble bits read as zero.
module system_bus_address_decoder #(
  parameter [31:0] SRAM_SIZE   = `SRAM_SIZE_32K,
  parameter [31:0] FLASH_SIZE  = `FLASH_SIZE_128K,
  parameter integer CLK_MHZ    = `SYS_CLK_MHZ
) (
  input  wire        clk,
  input  wire        srst,
  // Master request
  input  wire        req_valid,
  input  wire        req_write,
  input  wire [31:0] req_addr,
  input  wire [31:0] req_wdata,
  // Master answer
  output reg         resp_valid,
  output reg         resp_error,
  output reg  [31:0] resp_rdata,
  output reg         req_ready,
  // Target selects, one-cycle strobes with address
  output reg         sram_sel,
  output reg         usb_sel,
  output reg         bridge_a_sel,
  output reg         bridge_b_sel,
  output reg         flash_sel,
  output reg         tgt_write,
  output reg  [31:0] tgt_addr,
  output reg  [31:0] tgt_wdata,
  // Target read data, sampled when the answer is built
  input  wire [31:0] sram_rdata,
  input  wire [31:0] usb_rdata,
  input  wire [31:0] bridge_a_rdata,
  input  wire [31:0] bridge_b_rdata,
  input  wire [31:0] flash_rdata,
  // Priority register ports for the matrix
  input  wire        prio_a_we,
  input  wire        prio_b_we,
  input  wire [31:0] prio_wdata,
  output reg  [31:0] slave_priority_reg_a,
  output reg  [31:0] slave_priority_reg_b
);

  // Wait-state setting is fixed by the clock rate
  localparam [0:0] FLASH_WS =
    (CLK_MHZ <= `FLASH_WS0_MAX_MHZ) ? 1'b0 : 1'b1;

  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_FWAIT = 2'h1;
  localparam [1:0] ST_RESP  = 2'h2;

  wire [2:0]  target;
  wire [31:0] prio_stored;

  reg [1:0]   state_q;
  reg [1:0]   state_d;
  reg [2:0]   tgt_q;
  reg [31:0]  next_flash_q;   // Address the flash pipeline has prefetched
  reg         burst_ok_q;     // Pipeline holds the sequential next word

  // Plain address compare, no segment or boot translation in front
  addr_region_match #(
    .SRAM_SIZE  (SRAM_SIZE),
    .FLASH_SIZE (FLASH_SIZE)
  ) u_match (
    .addr   (req_addr),
    .target (target)
  );

  prio_field_mask u_prio (
    .wdata  (prio_wdata),
    .stored (prio_stored)
  );

  // Read data mux by target code
  function [31:0] pick_rdata;
    input [2:0]  t;
    input [31:0] d_sram;
    input [31:0] d_flash;
    input [31:0] d_usb;
    input [31:0] d_a;
    input [31:0] d_b;
    begin
      case (t)
        `TGT_SRAM:     pick_rdata = d_sram;
        `TGT_FLASH:    pick_rdata = d_flash;
        `TGT_USB:      pick_rdata = d_usb;
        `TGT_BRIDGE_A: pick_rdata = d_a;
        `TGT_BRIDGE_B: pick_rdata = d_b;
        default:       pick_rdata = 32'h0000_0000;
      endcase
    end
  endfunction

  // Above 30 MHz a flash read needs a wait unless it continues a prefetched burst
  wire flash_hit = burst_ok_q && (req_addr == next_flash_q);
  wire take      = req_valid && req_ready;
  wire needs_ws  = (target == `TGT_FLASH) && !req_write &&
                   FLASH_WS && !flash_hit;
  wire is_fread  = (target == `TGT_FLASH) && !req_write;

  // Timing overview for whoever integrates this decoder:
  // - a request is taken on a rising edge with req_valid and req_ready
  // - target strobes and the copied request appear one cycle later
  // - non-waited answers are built at the take edge from the target's
  //   read data, so targets must present read data combinationally
  // - a waited flash read answers one cycle later still, from the data
  //   the flash shows during the wait cycle
  // - req_ready is low for exactly that wait cycle; nothing is taken then
  // Keeping read data combinational saves a cycle on every access, at
  // the cost of a longer path from the targets into resp_rdata.

  // Answer the request taken now unless it has to wait for flash
  wire answer_now = take && !needs_ws;

  // Read data for a direct answer and for a waited flash answer
  wire [31:0] rdata_now  = pick_rdata(target, sram_rdata, flash_rdata,
                                      usb_rdata, bridge_a_rdata,
                                      bridge_b_rdata);
  wire [31:0] rdata_wait = pick_rdata(tgt_q, sram_rdata, flash_rdata,
                                      usb_rdata, bridge_a_rdata,
                                      bridge_b_rdata);

  // Strobe for one target: high only on a take that decodes to it
  function strobe_for;
    input       tk;
    input [2:0] t;
    input [2:0] code;
    begin
      strobe_for = tk && (t == code);
    end
  endfunction

  // Next-state logic
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (take) begin
          state_d = needs_ws ? ST_FWAIT : ST_RESP;
        end
      end
      ST_FWAIT: begin
        state_d = ST_RESP;
      end
      ST_RESP: begin
        // Back-to-back requests keep bursts at one word per cycle
        if (take) begin
          state_d = needs_ws ? ST_FWAIT : ST_RESP;
        end else begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // State register
  always @(posedge clk) begin
    if (srst) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // Ready drops for exactly the cycle a flash wait state is served
  always @(posedge clk) begin
    if (srst) begin
      req_ready <= 1'b0;
    end else begin
      req_ready <= (state_d != ST_FWAIT);
    end
  end

  // One-cycle target strobes; the fixed map makes them mutually exclusive
  always @(posedge clk) begin
    if (srst) begin
      sram_sel     <= 1'b0;
      flash_sel    <= 1'b0;
      usb_sel      <= 1'b0;
      bridge_a_sel <= 1'b0;
      bridge_b_sel <= 1'b0;
    end else begin
      sram_sel     <= strobe_for(take, target, `TGT_SRAM);
      flash_sel    <= strobe_for(take, target, `TGT_FLASH);
      usb_sel      <= strobe_for(take, target, `TGT_USB);
      bridge_a_sel <= strobe_for(take, target, `TGT_BRIDGE_A);
      bridge_b_sel <= strobe_for(take, target, `TGT_BRIDGE_B);
    end
  end

  // Copy of the taken request, held until the next take
  always @(posedge clk) begin
    if (srst) begin
      tgt_q     <= `TGT_NONE;
      tgt_write <= 1'b0;
      tgt_addr  <= 32'h0000_0000;
      tgt_wdata <= 32'h0000_0000;
    end else if (take) begin
      tgt_q     <= target;
      tgt_write <= req_write;
      tgt_addr  <= req_addr;
      tgt_wdata <= req_wdata;
    end
  end

  // Prefetch tracking: only a flash read arms the sequential hit, so a
  // write or another target in between makes the next flash read wait
  always @(posedge clk) begin
    if (srst) begin
      next_flash_q <= 32'h0000_0000;
      burst_ok_q   <= 1'b0;
    end else if (take) begin
      if (is_fread) begin
        next_flash_q <= req_addr + 32'h0000_0004;
        burst_ok_q   <= 1'b1;
      end else begin
        burst_ok_q   <= 1'b0;
      end
    end
  end

  // Answer one cycle after the take, or after the flash wait state;
  // no take can happen in the wait cycle since ready is low then
  always @(posedge clk) begin
    if (srst) begin
      resp_valid <= 1'b0;
      resp_error <= 1'b0;
      resp_rdata <= 32'h0000_0000;
    end else if (state_q == ST_FWAIT) begin
      resp_valid <= 1'b1;
      resp_error <= 1'b0;
      resp_rdata <= rdata_wait;
    end else if (answer_now) begin
      resp_valid <= 1'b1;
      resp_error <= (target == `TGT_NONE);
      resp_rdata <= rdata_now;
    end else begin
      resp_valid <= 1'b0;
      resp_error <= 1'b0;
    end
  end

  // Priority register A keeps only the two-bit fields
  always @(posedge clk) begin
    if (srst) begin
      slave_priority_reg_a <= 32'h0000_0000;
    end else if (prio_a_we) begin
      slave_priority_reg_a <= prio_stored;
    end
  end

  // Priority register B keeps only the two-bit fields
  always @(posedge clk) begin
    if (srst) begin
      slave_priority_reg_b <= 32'h0000_0000;
    end else if (prio_b_we) begin
      slave_priority_reg_b <= prio_stored;
    end
  end

endmodule // system_bus_address_decoder

//--- bench/bus_decode_checker.sv
// Port assertions for the system bus decoder
`timescale 1ns/1ps
`include "bus_decode_defines.vh"
module bus_decode_checker #(
  parameter [31:0] SRAM_SIZE  = `SRAM_SIZE_32K,
  parameter [31:0] FLASH_SIZE = `FLASH_SIZE_128K
) (
  input wire        clk,
  input wire        srst,
  input wire        req_valid,
  input wire [31:0] req_addr,
  input wire        req_ready,
  input wire        resp_valid,
  input wire        resp_error,
  input wire        sram_sel,
  input wire        flash_sel,
  input wire        usb_sel,
  input wire        bridge_a_sel,
  input wire        bridge_b_sel,
  input wire [31:0] slave_priority_reg_a
);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  // Region of the address taken at this edge
  wire        tk = req_valid && req_ready;
  wire [31:0] fo = req_addr - `FLASH_BASE;
  wire        s  = req_addr < SRAM_SIZE;
  wire        f  = req_addr[31] && fo < FLASH_SIZE;
  wire        u  = req_addr[31:16] == 16'hd000;
  wire        a  = req_addr[31:16] == 16'hffff;
  wire        b  = req_addr[31:16] == 16'hfffe;
  wire [4:0]  sl = {sram_sel, flash_sel, usb_sel, bridge_a_sel, bridge_b_sel};
  // Clean answer; flash may spend one wait cycle before it
  sequence ok; resp_valid && !resp_error; endsequence
  sequence fl; flash_sel ##[0:1] ok; endsequence
  a_sram_route: assert property (tk && s |=> sram_sel ##0 ok)
    else $error("sram access not answered next cycle");
  a_flash_route: assert property (tk && f |=> fl)
    else $error("flash access late or misrouted");
  a_usb_route: assert property (tk && u |=> usb_sel ##0 ok)
    else $error("usb window misrouted");
  a_bra_route: assert property (tk && a |=> bridge_a_sel ##0 ok)
    else $error("bridge a misrouted");
  a_brb_route: assert property (tk && b |=> bridge_b_sel ##0 ok)
    else $error("bridge b misrouted");
  a_bad_error: assert property (tk && !(s|f|u|a|b) |=>
    resp_valid && resp_error && sl == 5'h0)
    else $error("unmapped access not refused");
  a_one_target: assert property ($onehot0(sl))
    else $error("more than one target selected");
  a_prio_mask: assert property ((slave_priority_reg_a & 32'hcccc_cccc) == 0)
    else $error("priority field wider than two bits");
endmodule // bus_decode_checker

bind system_bus_address_decoder bus_decode_checker #(
  .SRAM_SIZE(SRAM_SIZE), .FLASH_SIZE(FLASH_SIZE)) chk (
  .clk(clk), .srst(srst), .req_valid(req_valid), .req_addr(req_addr),
  .req_ready(req_ready), .resp_valid(resp_valid), .resp_error(resp_error),
  .sram_sel(sram_sel), .flash_sel(flash_sel), .usb_sel(usb_sel),
  .bridge_a_sel(bridge_a_sel), .bridge_b_sel(bridge_b_sel),
  .slave_priority_reg_a(slave_priority_reg_a));

//--- bench/bus_target_stub.sv
// Target stubs that answer every read with a word of their own
`timescale 1ns/1ps
module bus_target_stub #(
  parameter [31:0] PAT = 32'h5a00_0000
) (
  output wire [31:0] sram_rdata,
  output wire [31:0] flash_rdata,
  output wire [31:0] usb_rdata,
  output wire [31:0] bridge_a_rdata,
  output wire [31:0] bridge_b_rdata
);
  // Distinct words so that a misrouted read cannot pass
  assign sram_rdata     = PAT | 32'h1;
  assign flash_rdata    = PAT | 32'h2;
  assign usb_rdata      = PAT | 32'h3;
  assign bridge_a_rdata = PAT | 32'h4;
  assign bridge_b_rdata = PAT | 32'h5;
endmodule // bus_target_stub

//--- bench/system_bus_address_decoder_tb.sv
// Self-checking bench for the system bus decoder
`timescale 1ns/1ps
module system_bus_address_decoder_tb;
  localparam [31:0] SSZ = 32'h8000, FSZ = 32'h2_0000, PAT = 32'h5a00_0000;
  logic clk, srst, req_valid, req_write, resp_valid, resp_error, req_ready;
  logic sram_sel, usb_sel, bridge_a_sel, bridge_b_sel, flash_sel, tgt_write;
  logic prio_a_we, prio_b_we, tk_q, w30_flash_sel, w30_resp_valid;
  logic [31:0] req_addr, req_wdata, resp_rdata, tgt_addr, tgt_wdata, prio_wdata;
  logic [31:0] sram_rdata, usb_rdata, bridge_a_rdata, bridge_b_rdata;
  logic [31:0] flash_rdata, slave_priority_reg_a, slave_priority_reg_b;
  logic [31:0] r, a_q, seed = 32'h0ca38478;
  logic [31:0] bs [5] = '{32'h0, 32'h8000_0000, 32'hd000_0000,
                          32'hffff_0000, 32'hfffe_0000};
  logic [31:0] sz [5] = '{SSZ, FSZ, 32'h1_0000, 32'h1_0000, 32'h1_0000};
  logic [3:0]  q [$];
  logic [3:0]  e;
  int fails = 0, n_tests = 0, cyc = 0, t0, i, j;

  system_bus_address_decoder #(.SRAM_SIZE(SSZ), .FLASH_SIZE(FSZ)) dut (
    .clk(clk), .srst(srst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(resp_valid),
    .resp_error(resp_error), .resp_rdata(resp_rdata), .req_ready(req_ready),
    .sram_sel(sram_sel), .usb_sel(usb_sel), .bridge_a_sel(bridge_a_sel),
    .bridge_b_sel(bridge_b_sel), .flash_sel(flash_sel), .tgt_write(tgt_write),
    .tgt_addr(tgt_addr), .tgt_wdata(tgt_wdata), .sram_rdata(sram_rdata),
    .usb_rdata(usb_rdata), .bridge_a_rdata(bridge_a_rdata),
    .bridge_b_rdata(bridge_b_rdata), .flash_rdata(flash_rdata),
    .prio_a_we(prio_a_we), .prio_b_we(prio_b_we), .prio_wdata(prio_wdata),
    .slave_priority_reg_a(slave_priority_reg_a),
    .slave_priority_reg_b(slave_priority_reg_b));
  // Same decoder at 30 MHz: flash must answer with no wait state
  system_bus_address_decoder #(.SRAM_SIZE(SSZ), .FLASH_SIZE(FSZ),
    .CLK_MHZ(30)) dut30 (
    .clk(clk), .srst(srst), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .resp_valid(w30_resp_valid),
    .resp_error(), .resp_rdata(), .req_ready(), .sram_sel(), .usb_sel(),
    .bridge_a_sel(), .bridge_b_sel(), .flash_sel(w30_flash_sel),
    .tgt_write(), .tgt_addr(), .tgt_wdata(), .sram_rdata(sram_rdata),
    .usb_rdata(usb_rdata), .bridge_a_rdata(bridge_a_rdata),
    .bridge_b_rdata(bridge_b_rdata), .flash_rdata(flash_rdata),
    .prio_a_we(prio_a_we), .prio_b_we(prio_b_we), .prio_wdata(prio_wdata),
    .slave_priority_reg_a(), .slave_priority_reg_b());
  bus_target_stub #(.PAT(PAT)) stub (.sram_rdata(sram_rdata),
    .flash_rdata(flash_rdata), .usb_rdata(usb_rdata),
    .bridge_a_rdata(bridge_a_rdata), .bridge_b_rdata(bridge_b_rdata));

  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    #400000;
    fails++;
    conclude;
  end
  function automatic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected target code for an address
  function automatic [2:0] tg(input logic [31:0] a);
    if (a < SSZ) return 3'h1;
    if (a[31] && a - 32'h8000_0000 < FSZ) return 3'h2;
    if (a[31:16] == 16'hd000) return 3'h3;
    if (a[31:16] == 16'hffff) return 3'h4;
    if (a[31:16] == 16'hfffe) return 3'h5;
    return 3'h0;
  endfunction
  task automatic chk(input string n, input logic [31:0] x, g);
    n_tests++;
    if (g !== x) begin
      fails++;
      $display("BAD %s exp %h got %h", n, x, g);
    end
  endtask
  // Hold the request until taken; stays valid for a back-to-back follower
  task automatic req(input logic w, input logic [31:0] a);
    int k;
    req_valid = 1;
    req_write = w;
    req_addr = a;
    req_wdata = xs();
    k = 0;
    @(posedge clk);
    while (req_ready !== 1'b1 && k < 20) begin
      @(posedge clk);
      k++;
    end
    if (k == 20) begin
      fails++;
      conclude;
    end
    @(negedge clk);
  endtask
  task automatic conclude;
    $display("fails=%0d n_tests=%0d", fails, n_tests);
    if (fails == 0 && n_tests > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // Record each taken request; a reset drops what was in flight
  always @(posedge clk) begin
    cyc <= cyc + 1;
    tk_q <= req_valid && req_ready && !srst;
    a_q <= req_addr;
    if (srst) q.delete();
    else if (req_valid && req_ready) q.push_back({req_write, tg(req_addr)});
  end
  always @(negedge clk) begin
    if (tk_q) chk("tgt_addr", a_q, tgt_addr);
    if (w30_flash_sel === 1'b1) chk("ws0_resp", 1, w30_resp_valid);
    if (resp_valid === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      chk("resp_error", {31'h0, e[2:0] == 0}, {31'h0, resp_error});
      if (!e[3] && e[2:0] != 0) chk("rdata", PAT | e[2:0], resp_rdata);
    end
  end
  initial begin
    {srst, req_valid, req_write, prio_a_we, prio_b_we} = 5'h10;
    {req_addr, req_wdata, prio_wdata} = '0;
    repeat (12) @(negedge clk);
    srst = 0;
    @(negedge clk);
    // Base, last word and first word past each window
    for (i = 0; i < 5; i++) begin
      req(0, bs[i]);
      req(1, bs[i] + sz[i] - 4);
      req(0, bs[i] + sz[i]);
    end
    // Four back-to-back reads: sram one per cycle, flash one extra cycle
    for (j = 0; j < 2; j++) begin
      req_valid = 0;
      @(negedge clk);
      t0 = cyc;
      for (i = 0; i < 4; i++) req(0, bs[j] + 32'h100 + 4 * i);
      chk("burst_cycles", j ? 5 : 4, cyc - t0);
    end
    repeat (300) begin
      r = xs();
      req(r[0], r[1] ? bs[r[4:2] % 5] + (r & 32'h1_fffc) : xs());
    end
    req_valid = 0;
    repeat (8) begin
      prio_wdata = xs();
      {prio_a_we, prio_b_we} = 2'b11;
      @(negedge clk);
      {prio_a_we, prio_b_we} = 2'b00;
      chk("prio_a", prio_wdata & 32'h3333_3333, slave_priority_reg_a);
      chk("prio_b", prio_wdata & 32'h3333_3333, slave_priority_reg_b);
    end
    // Second reset; the map stays fixed in the boot phase
    srst = 1;
    repeat (2) @(negedge clk);
    srst = 0;
    @(negedge clk);
    req(0, 32'h0);
    req_valid = 0;
    repeat (4) @(negedge clk);
    chk("pending", 0, q.size());
    conclude;
  end
endmodule // system_bus_address_decoder_tb
